// >>> hw/tcin_defs.svh
// Constants of the two-channel thermocouple input parameter block.
// Assumes inclusion by the design files; definitions only.
`ifndef TCIN_DEFS_SVH
`define TCIN_DEFS_SVH

// ----------------------------------------------------------------
// Parameter byte indices, in table order
// ----------------------------------------------------------------
`define TCIN_IDX_DIAG 3'h0
`define TCIN_IDX_WBRK 3'h1
`define TCIN_IDX_UNIT 3'h2
`define TCIN_IDX_SUPP 3'h3
`define TCIN_IDX_FN0 3'h4
`define TCIN_IDX_FN1 3'h5

// ----------------------------------------------------------------
// Record sets, fieldbus indices and subindices
// ----------------------------------------------------------------
`define TCIN_REC_SYS 8'h00
`define TCIN_REC_CFG 8'h01
`define TCIN_REC_FN0 8'h80
`define TCIN_REC_FN1 8'h81
`define TCIN_IX_BASE 16'h3100
`define TCIN_IX_LAST 16'h3105
`define TCIN_SX_FIRST 8'h01
`define TCIN_SX_LAST 8'h06

// ----------------------------------------------------------------
// Field values and reset values
// ----------------------------------------------------------------
`define TCIN_DIAG_ON 8'h40
`define TCIN_DIAG_BIT 6
`define TCIN_DIAG_RST 8'h00
`define TCIN_WBRK_RST 8'h00
`define TCIN_UNIT_RST 8'h00
`define TCIN_SUPP_RST 8'h02
`define TCIN_FN_RST 8'hC1
`define TCIN_SUPP_60 2'h1
`define TCIN_SUPP_50 2'h2

// ----------------------------------------------------------------
// Function numbers
// ----------------------------------------------------------------
// HI scales 80mV to 27648 digits, LO scales it to 16384 digits
`define TCIN_FN_MV_HI 8'h11
`define TCIN_FN_MV_LO 8'h21
`define TCIN_FN_J_EXT 8'hB0
`define TCIN_FN_K_EXT 8'hB1
`define TCIN_FN_J_INT 8'hC0
`define TCIN_FN_K_INT 8'hC1
`define TCIN_FN_OFF 8'hFF

// ----------------------------------------------------------------
// Scaling coefficients (Q16) and limits, as 16-bit two's complement
// ----------------------------------------------------------------
`define TCIN_K_MVHI 18'h0_5879
`define TCIN_K_MVLO 18'h0_346E
`define TCIN_K_F 18'h1_CCCD
`define TCIN_F_OFS 18'h0_0140
`define TCIN_K_OFS 18'h0_0AAC
`define TCIN_MVHI_OVR 16'h7EFF
`define TCIN_MVHI_UND 16'h8100
`define TCIN_MVLO_OVR 16'h5000
`define TCIN_MVLO_UND 16'hB000
`define TCIN_J_OVR 16'h38A4
`define TCIN_J_UND 16'hF7CC
`define TCIN_K_OVR 16'h3F5C
`define TCIN_K_UND 16'hF574
`define TCIN_VAL_MAX 16'h7FFF
`define TCIN_VAL_MIN 16'h8000

`endif

// >>> hw/tcin_pkg.sv
// Types shared by the thermocouple input parameter block.
// Assumes the constants header sits beside it.
package tcin_pkg;
  // Addressing scheme used by the bus coupler
  typedef enum logic [1:0] {
    TCIN_ACC_RECORD = 2'b00,
    TCIN_ACC_INDEX = 2'b01,
    TCIN_ACC_SUBIDX = 2'b10
  } tcin_acc_mode_t;

  // Temperature unit field
  typedef enum logic [1:0] {
    TCIN_UNIT_C = 2'b00,
    TCIN_UNIT_F = 2'b01,
    TCIN_UNIT_K = 2'b10
  } tcin_unit_t;
endpackage : tcin_pkg

// >>> hw/tcin_scale.sv
// Value encoder for one channel: range decode, scaling and limiting.
// Assumes raw inputs are already linearised; purely combinational.
`timescale 1ns/10ps
`default_nettype none
`include "tcin_defs.svh"
module tcin_scale
  import tcin_pkg::*;
(
  // Configuration
  input wire logic [7:0] range_code_i,
  input wire logic [1:0] unit_i,
  // Raw measurement
  input wire logic signed [17:0] raw_uv_i,
  input wire logic signed [15:0] raw_dc_i,
  // Encoded result
  output logic [15:0] value_o,
  output logic over_o,
  output logic under_o,
  output logic off_o,
  output logic bad_code_o
);
  logic signed [35:0] prod_v;
  logic signed [19:0] dig_v;
  logic signed [35:0] prod_f;
  logic signed [17:0] temp_x;
  logic signed [15:0] ovr_lim;
  logic signed [15:0] und_lim;
  logic is_mv;
  logic is_tc;
  logic signed [17:0] k_sel;

  // ----------------------------------------------------------------
  // Range decode
  // ----------------------------------------------------------------
  always_comb begin
    is_mv = 1'b0;
    is_tc = 1'b0;
    off_o = 1'b0;
    bad_code_o = 1'b0;
    k_sel = `TCIN_K_MVHI;
    ovr_lim = `TCIN_MVHI_OVR;
    und_lim = `TCIN_MVHI_UND;
    case (range_code_i)
      `TCIN_FN_MV_HI: begin
        is_mv = 1'b1;
      end
      `TCIN_FN_MV_LO: begin
        is_mv = 1'b1;
        k_sel = `TCIN_K_MVLO;
        ovr_lim = `TCIN_MVLO_OVR;
        und_lim = `TCIN_MVLO_UND;
      end
      `TCIN_FN_J_EXT, `TCIN_FN_J_INT: begin
        is_tc = 1'b1;
        ovr_lim = `TCIN_J_OVR;
        und_lim = `TCIN_J_UND;
      end
      `TCIN_FN_K_EXT, `TCIN_FN_K_INT: begin
        is_tc = 1'b1;
        ovr_lim = `TCIN_K_OVR;
        und_lim = `TCIN_K_UND;
      end
      `TCIN_FN_OFF: off_o = 1'b1;
      default: bad_code_o = 1'b1;
    endcase
  end

  // Q16 fixed point keeps the scaler to one multiplier per path
  assign prod_v = raw_uv_i * k_sel;
  assign dig_v = prod_v[35:16];
  assign prod_f = 36'(raw_dc_i) * `TCIN_K_F;

  // ----------------------------------------------------------------
  // Unit conversion and limiting
  // ----------------------------------------------------------------
  always_comb begin
    temp_x = 18'(raw_dc_i);
    if (unit_i == TCIN_UNIT_F) begin
      temp_x = prod_f[33:16] + `TCIN_F_OFS;
    end else if (unit_i == TCIN_UNIT_K) begin
      temp_x = 18'(raw_dc_i) + `TCIN_K_OFS;
    end
    value_o = 16'h0000;
    over_o = 1'b0;
    under_o = 1'b0;
    if (is_mv) begin
      if (dig_v > 20'(ovr_lim)) begin
        over_o = 1'b1;
        value_o = `TCIN_VAL_MAX;
      end else if (dig_v < 20'(und_lim)) begin
        under_o = 1'b1;
        value_o = `TCIN_VAL_MIN;
      end else begin
        value_o = dig_v[15:0];
      end
    end else if (is_tc) begin
      // Limits are judged in Celsius, before unit conversion
      if (raw_dc_i > ovr_lim) begin
        over_o = 1'b1;
        value_o = `TCIN_VAL_MAX;
      end else if (raw_dc_i < und_lim) begin
        under_o = 1'b1;
        value_o = `TCIN_VAL_MIN;
      end else begin
        value_o = temp_x[15:0];
      end
    end
  end
endmodule : tcin_scale
`default_nettype wire

// >>> hw/tcin_param.sv
// Parameter store and channel result registers of the thermocouple input.
// Assumes a bus coupler on the same clock issuing one access per request.
`timescale 1ns/10ps
`default_nettype none
`include "tcin_defs.svh"
module tcin_param
  import tcin_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // Parameter access from the bus coupler
  input wire logic acc_req_i,
  input wire logic acc_wr_i,
  input wire logic [1:0] acc_mode_i,
  input wire logic [15:0] acc_index_i,
  input wire logic [7:0] acc_sub_i,
  input wire logic [7:0] acc_wdata_i,
  input wire logic [7:0] slot_i,
  input wire logic sys_stopped_i,
  output logic acc_ack_o,
  output logic acc_err_o,
  output logic [7:0] acc_rdata_o,
  // Front-end measurement
  input wire logic [1:0] ch_sample_i,
  input wire logic [1:0][17:0] ch_raw_uv_i,
  input wire logic [1:0][15:0] ch_raw_dc_i,
  input wire logic [1:0] ch_open_i,
  // Configuration towards the front end
  output logic diag_irq_enable_o,
  output logic [1:0] wire_break_enable_o,
  output logic [1:0] temperature_unit_o,
  output logic supp_60hz_o,
  output logic [1:0] ch_enable_o,
  output logic param_err_o,
  // Encoded results
  output logic [1:0][15:0] ch_value_o,
  output logic [1:0] ch_over_o,
  output logic [1:0] ch_under_o,
  output logic [1:0] ch_wire_break_o
);
  // ----------------------------------------------------------------
  // Parameter bytes and access decode
  // ----------------------------------------------------------------
  logic diag_r, diag_nxt;
  logic [1:0] wbrk_r, wbrk_nxt;
  logic [1:0] unit_r, unit_nxt;
  logic [1:0] supp_r, supp_nxt;
  logic [1:0][7:0] fn_r, fn_nxt;
  logic ack_r, ack_nxt;
  logic err_r, err_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic hit;
  logic [2:0] idx;
  logic refuse;
  logic [1:0] ch_off;
  logic [1:0] ch_bad;

  // Resolve the three addressing schemes to one byte index
  always_comb begin
    hit = 1'b0;
    idx = `TCIN_IDX_DIAG;
    case (acc_mode_i)
      TCIN_ACC_RECORD: begin
        if (acc_index_i == 16'(`TCIN_REC_SYS) && acc_sub_i < 8'h02) begin
          hit = 1'b1;
          idx = (acc_sub_i == 8'h00) ? `TCIN_IDX_DIAG : `TCIN_IDX_WBRK;
        end else if (acc_index_i == 16'(`TCIN_REC_CFG) && acc_sub_i < 8'h02) begin
          hit = 1'b1;
          idx = (acc_sub_i == 8'h00) ? `TCIN_IDX_UNIT : `TCIN_IDX_SUPP;
        end else if (acc_index_i == 16'(`TCIN_REC_FN0) && acc_sub_i == 8'h00) begin
          hit = 1'b1;
          idx = `TCIN_IDX_FN0;
        end else if (acc_index_i == 16'(`TCIN_REC_FN1) && acc_sub_i == 8'h00) begin
          hit = 1'b1;
          idx = `TCIN_IDX_FN1;
        end
      end
      TCIN_ACC_INDEX: begin
        if (acc_index_i >= `TCIN_IX_BASE && acc_index_i <= `TCIN_IX_LAST) begin
          hit = 1'b1;
          idx = 3'(acc_index_i - `TCIN_IX_BASE);
        end
      end
      TCIN_ACC_SUBIDX: begin
        if (acc_index_i == `TCIN_IX_BASE + 16'(slot_i)
            && acc_sub_i >= `TCIN_SX_FIRST && acc_sub_i <= `TCIN_SX_LAST) begin
          hit = 1'b1;
          idx = 3'(acc_sub_i - `TCIN_SX_FIRST);
        end
      end
      default: hit = 1'b0;
    endcase
  end

  // Writes to the stop-only record are refused in run state
  assign refuse = acc_wr_i && !sys_stopped_i
    && (idx == `TCIN_IDX_DIAG || idx == `TCIN_IDX_WBRK);

  // Next values of the parameter bytes and the access answer
  always_comb begin
    diag_nxt = diag_r;
    wbrk_nxt = wbrk_r;
    unit_nxt = unit_r;
    supp_nxt = supp_r;
    fn_nxt = fn_r;
    ack_nxt = 1'b0;
    err_nxt = 1'b0;
    rdata_nxt = rdata_r;
    if (acc_req_i) begin
      ack_nxt = 1'b1;
      if (!hit || refuse) begin
        err_nxt = 1'b1;
        rdata_nxt = 8'h00;
      end else if (acc_wr_i) begin
        // Reserved bits are dropped on the way in, except for diag, which any byte but 8'h40 clears
        case (idx)
          `TCIN_IDX_DIAG: diag_nxt = (acc_wdata_i == `TCIN_DIAG_ON);
          `TCIN_IDX_WBRK: wbrk_nxt = acc_wdata_i[1:0];
          `TCIN_IDX_UNIT: unit_nxt = acc_wdata_i[1:0];
          `TCIN_IDX_SUPP: supp_nxt = acc_wdata_i[1:0];
          `TCIN_IDX_FN0: fn_nxt[0] = acc_wdata_i;
          `TCIN_IDX_FN1: fn_nxt[1] = acc_wdata_i;
          default: err_nxt = 1'b1;
        endcase
      end else begin
        case (idx)
          `TCIN_IDX_DIAG: rdata_nxt = {1'b0, diag_r, 6'h00};
          `TCIN_IDX_WBRK: rdata_nxt = {6'h00, wbrk_r};
          `TCIN_IDX_UNIT: rdata_nxt = {6'h00, unit_r};
          `TCIN_IDX_SUPP: rdata_nxt = {6'h00, supp_r};
          `TCIN_IDX_FN0: rdata_nxt = fn_r[0];
          `TCIN_IDX_FN1: rdata_nxt = fn_r[1];
          default: err_nxt = 1'b1;
        endcase
      end
    end
  end

  // Parameter registers
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      diag_r <= `TCIN_DIAG_RST == `TCIN_DIAG_ON;
      // Reset bytes are eight bits wide; only the live field bits are kept
      wbrk_r <= 2'(`TCIN_WBRK_RST);
      unit_r <= 2'(`TCIN_UNIT_RST);
      supp_r <= 2'(`TCIN_SUPP_RST);
      fn_r <= {`TCIN_FN_RST, `TCIN_FN_RST};
      ack_r <= 1'b0;
      err_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      diag_r <= diag_nxt;
      wbrk_r <= wbrk_nxt;
      unit_r <= unit_nxt;
      supp_r <= supp_nxt;
      fn_r <= fn_nxt;
      ack_r <= ack_nxt;
      err_r <= err_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign acc_ack_o = ack_r;
  assign acc_err_o = err_r;
  assign acc_rdata_o = rdata_r;
  assign diag_irq_enable_o = diag_r;
  assign wire_break_enable_o = wbrk_r;
  assign temperature_unit_o = unit_r;
  // Only 01 picks 60Hz; the undefined codes fall back to 50Hz
  assign supp_60hz_o = (supp_r == `TCIN_SUPP_60);
  assign ch_enable_o = ~ch_off;
  assign param_err_o = (|ch_bad) || (unit_r == 2'b11)
    || (supp_r != `TCIN_SUPP_60 && supp_r != `TCIN_SUPP_50);

  // ----------------------------------------------------------------
  // Per-channel encoding and result registers
  // ----------------------------------------------------------------
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [15:0] enc_val;
    logic enc_over, enc_under;
    logic [15:0] val_r, val_nxt;
    logic over_r, over_nxt;
    logic under_r, under_nxt;
    logic wb_r, wb_nxt;

    tcin_scale u_scale (
      .range_code_i(fn_r[c]),
      .unit_i(unit_r),
      .raw_uv_i(ch_raw_uv_i[c]),
      .raw_dc_i(ch_raw_dc_i[c]),
      .value_o(enc_val),
      .over_o(enc_over),
      .under_o(enc_under),
      .off_o(ch_off[c]),
      .bad_code_o(ch_bad[c])
    );

    // A switched-off channel clears its result at the next clock edge, without waiting for a sample
    always_comb begin
      val_nxt = val_r;
      over_nxt = over_r;
      under_nxt = under_r;
      wb_nxt = wbrk_r[c] && ch_open_i[c];
      if (ch_off[c]) begin
        val_nxt = 16'h0000;
        over_nxt = 1'b0;
        under_nxt = 1'b0;
        wb_nxt = 1'b0;
      end else if (ch_sample_i[c]) begin
        val_nxt = enc_val;
        over_nxt = enc_over;
        under_nxt = enc_under;
      end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        val_r <= 16'h0000;
        over_r <= 1'b0;
        under_r <= 1'b0;
        wb_r <= 1'b0;
      end else begin
        val_r <= val_nxt;
        over_r <= over_nxt;
        under_r <= under_nxt;
        wb_r <= wb_nxt;
      end
    end

    assign ch_value_o[c] = val_r;
    assign ch_over_o[c] = over_r;
    assign ch_under_o[c] = under_r;
    assign ch_wire_break_o[c] = wb_r;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_diag_on;
    acc_req_i && acc_wr_i && hit && !refuse && idx == `TCIN_IDX_DIAG
      && acc_wdata_i == `TCIN_DIAG_ON |=> diag_irq_enable_o;
  endproperty
  a_diag_on: assert property (p_diag_on) else $error("diag enable not set");

  property p_wb_gate;
    ch_wire_break_o[0] |-> $past(wire_break_enable_o[0]) && $past(ch_open_i[0]);
  endproperty
  a_wb_gate: assert property (p_wb_gate) else $error("wire break without enable");

  property p_unit_wr;
    acc_req_i && acc_wr_i && hit && idx == `TCIN_IDX_UNIT
      |=> temperature_unit_o == $past(acc_wdata_i[1:0]);
  endproperty
  a_unit_wr: assert property (p_unit_wr) else $error("unit not stored");

  property p_supp_60;
    acc_req_i && acc_wr_i && hit && idx == `TCIN_IDX_SUPP && acc_wdata_i[1:0] == 2'b01
      |=> supp_60hz_o;
  endproperty
  a_supp_60: assert property (p_supp_60) else $error("60Hz not selected");

  property p_off;
    fn_r[1] == `TCIN_FN_OFF |-> !ch_enable_o[1] ##1 ch_value_o[1] == 16'h0000;
  endproperty
  a_off: assert property (p_off) else $error("channel not off");

  property p_run_refuse;
    acc_req_i && acc_wr_i && !sys_stopped_i && hit && idx == `TCIN_IDX_WBRK
      |=> acc_err_o && $stable(wire_break_enable_o);
  endproperty
  a_run_refuse: assert property (p_run_refuse) else $error("run write taken");

  property p_unmapped;
    acc_req_i && acc_mode_i == TCIN_ACC_SUBIDX && acc_index_i != `TCIN_IX_BASE + 16'(slot_i)
      |=> acc_ack_o && acc_err_o;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("bad index accepted");

  property p_mv_over;
    fn_r[0] == `TCIN_FN_MV_HI && ch_sample_i[0]
      && g_ch[0].u_scale.dig_v > $signed(20'(`TCIN_MVHI_OVR))
      |=> ch_value_o[0] == `TCIN_VAL_MAX && ch_over_o[0];
  endproperty
  a_mv_over: assert property (p_mv_over) else $error("millivolt overrange wrong");

  property p_k_celsius;
    (fn_r[0] == `TCIN_FN_K_INT || fn_r[0] == `TCIN_FN_K_EXT) && unit_r == 2'b00 && ch_sample_i[0]
      && $signed(ch_raw_dc_i[0]) <= $signed(`TCIN_K_OVR)
      && $signed(ch_raw_dc_i[0]) >= $signed(`TCIN_K_UND)
      |=> ch_value_o[0] == $past(ch_raw_dc_i[0]);
  endproperty
  a_k_celsius: assert property (p_k_celsius) else $error("type K Celsius wrong");

  property p_rsvd_rd;
    acc_ack_o && !acc_err_o && $past(acc_req_i) && !$past(acc_wr_i)
      && $past(idx) == `TCIN_IDX_WBRK |-> acc_rdata_o[7:2] == 6'h00;
  endproperty
  a_rsvd_rd: assert property (p_rsvd_rd) else $error("reserved bits set");

  c_wr_fn: cover property (acc_req_i && acc_wr_i && hit && idx == `TCIN_IDX_FN1 ##1 acc_ack_o);
  c_refused: cover property (acc_req_i && refuse ##1 acc_err_o);
  c_over: cover property (ch_over_o[0]);
  c_wbrk: cover property (ch_wire_break_o[1]);
endmodule : tcin_param
`default_nettype wire

// >>> tb/tcin_coupler_model.sv
// Bus coupler model: issues parameter accesses and owns the stop state.
// Assumes the testbench calls its tasks and checks the answers itself.
`timescale 1ns/10ps
`default_nettype none
module tcin_coupler_model #(
  parameter logic [7:0] SLOT = 8'h03
) (
  // Clock
  input wire logic core_clk_i,
  // Access towards the parameter store
  output logic acc_req_o,
  output logic acc_wr_o,
  output logic [1:0] acc_mode_o,
  output logic [15:0] acc_index_o,
  output logic [7:0] acc_sub_o,
  output logic [7:0] acc_wdata_o,
  output logic [7:0] slot_o,
  output logic sys_stopped_o
);
  // ----------------------------------------------------------------
  // Access driving
  // ----------------------------------------------------------------
  // Idle bus at time zero; address lines hold a pattern, not a request
  initial begin
    acc_req_o = 1'b0;
    acc_wr_o = 1'b0;
    acc_mode_o = 2'h0;
    acc_index_o = 16'hA5A5;
    acc_sub_o = 8'h5A;
    acc_wdata_o = 8'h5A;
    slot_o = SLOT;
    sys_stopped_o = 1'b0;
  end

  // Stop state; diag and wire-break writes follow a stop unless a refusal is wanted
  task automatic stop(input logic s);
    @(negedge core_clk_i);
    sys_stopped_o = s;
  endtask : stop

  // One request held over one rising edge; back to back if called again
  task automatic raw(input logic [1:0] m, input logic [15:0] ix, input logic [7:0] sx,
                     input logic w, input logic [7:0] d);
    @(negedge core_clk_i);
    acc_req_o = 1'b1;
    acc_wr_o = w;
    acc_mode_o = m;
    acc_index_o = ix;
    acc_sub_o = sx;
    acc_wdata_o = d;
    @(posedge core_clk_i);
  endtask : raw

  // Byte index to address in each scheme
  task automatic xfer(input logic [1:0] m, input logic [2:0] i, input logic w,
                      input logic [7:0] d);
    case (m)
      2'd0: raw(m, {8'h00, i < 3'd2 ? 8'h00 : i < 3'd4 ? 8'h01 : {7'h40, i[0]}},
                i < 3'd4 ? {7'h00, i[0]} : 8'h00, w, d);
      2'd1: raw(m, 16'h3100 + {13'h0, i}, ~acc_sub_o, w, d);
      default: raw(m, 16'h3100 + {8'h00, slot_o}, {5'h0, i} + 8'h01, w, d);
    endcase
  endtask : xfer

  // Release: request drops, index, subindex and write data stop showing the old values
  task automatic idle;
    @(negedge core_clk_i);
    acc_req_o = 1'b0;
    acc_wdata_o = ~acc_wdata_o;
    acc_index_o = ~acc_index_o;
    acc_sub_o = ~acc_sub_o;
  endtask : idle
endmodule : tcin_coupler_model
`default_nettype wire

// >>> tb/thermocouple_input_param_block_bench.sv
// Self-checking bench of the parameter store and result encoder.
// Assumes the coupler model drives all access inputs.
`timescale 1ns/10ps
`default_nettype none
module thermocouple_input_param_block_bench;
  import tcin_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic core_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  wire logic req, wr, stp;
  wire logic [1:0] mode;
  wire logic [15:0] index;
  wire logic [7:0] sub, wdata, slot;
  logic [1:0] ch_sample_i = 2'b00;
  logic [1:0] ch_open_i = 2'b00;
  logic [1:0][17:0] ch_raw_uv_i = '0;
  logic [1:0][15:0] ch_raw_dc_i = '0;
  logic ack, err, diag, s60, perr;
  logic [7:0] rdata;
  logic [1:0] wbe, unit, ch_en, ovr, und, wbo;
  logic [1:0][15:0] val;
  logic [16:0] aq[$];
  logic [49:0] mq[$];
  logic [16:0] ea;
  logic [49:0] em;
  logic [7:0] shd[6] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'hC1, 8'hC1};
  logic smp_r = 1'b0;
  integer seed = 87398;
  integer err_total = 0;
  integer checks_done = 0;
  integer cyc = 0;

  always #10 core_clk_i = ~core_clk_i;

  tcin_coupler_model i_tcin_coupler_model (.core_clk_i(core_clk_i), .acc_req_o(req),
    .acc_wr_o(wr), .acc_mode_o(mode), .acc_index_o(index), .acc_sub_o(sub),
    .acc_wdata_o(wdata), .slot_o(slot), .sys_stopped_o(stp));

  tcin_param i_tcin_param (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .acc_req_i(req),
    .acc_wr_i(wr), .acc_mode_i(mode), .acc_index_i(index), .acc_sub_i(sub),
    .acc_wdata_i(wdata), .slot_i(slot), .sys_stopped_i(stp), .acc_ack_o(ack),
    .acc_err_o(err), .acc_rdata_o(rdata), .ch_sample_i(ch_sample_i),
    .ch_raw_uv_i(ch_raw_uv_i), .ch_raw_dc_i(ch_raw_dc_i), .ch_open_i(ch_open_i),
    .diag_irq_enable_o(diag), .wire_break_enable_o(wbe), .temperature_unit_o(unit),
    .supp_60hz_o(s60), .ch_enable_o(ch_en), .param_err_o(perr), .ch_value_o(val),
    .ch_over_o(ovr), .ch_under_o(und), .ch_wire_break_o(wbo));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [49:0] seen, input logic [49:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    $display("mismatches %0d, checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  // Hang guard: the sequence needs well under a thousand cycles
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      print_verdict;
    end
  end

  // A sample taken at this edge means a result to compare next half cycle
  always @(posedge core_clk_i) begin
    smp_r <= ch_sample_i[0];
  end

  // Monitor: each answer or result takes the oldest note
  always @(negedge core_clk_i) begin
    if (ack === 1'b1) begin
      ea = aq.size() > 0 ? aq.pop_front() : 17'h1_FFFF;
      check(50'({err, rdata & ea[16:9]}), 50'(ea[8:0]));
    end
    if (smp_r) begin
      em = mq.pop_front();
      check(50'({val[0] & em[49:34], ovr[0], und[0], val[1], ovr[1], und[1]}),
            50'({em[33:0], 2'b00}));
    end
  end

  // ----------------------------------------------------------------
  // Drivers that note what must come back
  // ----------------------------------------------------------------
  task automatic acc(input logic [1:0] m, input logic [2:0] i, input logic w,
                     input logic [7:0] d);
    logic refuse;
    refuse = w && i < 3'd2 && !stp;
    if (w && !refuse) begin
      shd[i] = i == 3'd0 ? (d == 8'h40 ? 8'h40 : 8'h00) : i < 3'd4 ? d & 8'h03 : d;
    end
    aq.push_back(refuse ? 17'h0_FF00 | 17'h100 : w ? 17'h0 : {8'hFF, 1'b0, shd[i]});
    i_tcin_coupler_model.xfer(m, i, w, d);
  endtask : acc

  task automatic bad(input logic [1:0] m, input logic [15:0] ix, input logic [7:0] sx);
    aq.push_back({8'hFF, 9'h100});
    i_tcin_coupler_model.raw(m, ix, sx, 1'b0, 8'h00);
  endtask : bad

  task automatic chk_cfg;
    i_tcin_coupler_model.idle;
    @(negedge core_clk_i);
    check(50'({diag, wbe, unit, s60, ch_en, perr}), 50'({shd[0] == 8'h40, shd[1][1:0],
          shd[2][1:0], shd[3][1:0] == 2'b01, shd[5] != 8'hFF, shd[4] != 8'hFF,
          shd[2][1:0] == 2'b11 || shd[3][1] == shd[3][0]}));
  endtask : chk_cfg

  // Channel 0 gets the case under test, channel 1 a random type K reading
  task automatic meas(input logic [7:0] fn, input logic [1:0] u, input logic [17:0] uv,
                      input logic [15:0] dc, input logic [15:0] v, input logic ov,
                      input logic un, input logic [15:0] mk);
    logic [15:0] r1;
    acc(2'd0, 3'd4, 1'b1, fn);
    acc(2'd0, 3'd2, 1'b1, {6'h00, u});
    chk_cfg;
    r1 = 16'($unsigned($random(seed)) % 13721);
    ch_sample_i = 2'b11;
    ch_raw_uv_i = {18'($random(seed)), uv};
    ch_raw_dc_i = {r1, dc};
    mq.push_back({mk, v & mk, ov, un, u == 2'b01 ? 16'((32'(r1) * 117965) >>> 16) + 16'd320 :
                  u == 2'b10 ? r1 + 16'd2732 : r1});
    @(negedge core_clk_i);
    ch_sample_i = 2'b00;
  endtask : meas

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge core_clk_i);
    @(negedge core_clk_i);
    arst_n_i = 1'b1;
    // Reset values, read through record sets
    for (int i = 0; i < 6; i++) acc(2'd0, 3'(i), 1'b0, 8'h00);
    chk_cfg;
    // Back-to-back writes by object index while stopped, read back by subindex
    i_tcin_coupler_model.stop(1'b1);
    acc(2'd1, 3'd0, 1'b1, 8'hFF);
    acc(2'd1, 3'd0, 1'b1, 8'h40);
    acc(2'd1, 3'd1, 1'b1, 8'hFD);
    acc(2'd1, 3'd2, 1'b1, 8'hFD);
    acc(2'd1, 3'd3, 1'b1, 8'hF1);
    acc(2'd1, 3'd5, 1'b1, 8'hFF);
    for (int i = 0; i < 6; i++) acc(2'd2, 3'(i), 1'b0, 8'h00);
    chk_cfg;
    ch_open_i = 2'b11;
    repeat (2) @(negedge core_clk_i);
    check(50'(wbo), 50'(shd[1][1:0]));
    // Running: stop-only writes refused, unmapped places answered with error
    i_tcin_coupler_model.stop(1'b0);
    acc(2'd0, 3'd0, 1'b1, 8'h00);
    acc(2'd1, 3'd1, 1'b1, 8'h00);
    acc(2'd0, 3'd0, 1'b0, 8'h00);
    bad(2'd3, 16'h3100, 8'h01);
    bad(2'd0, 16'h0002, 8'h00);
    bad(2'd1, 16'h3106, 8'h00);
    bad(2'd0, 16'h0001, 8'h02);
    bad(2'd2, 16'h3100, 8'h01);
    acc(2'd2, 3'd2, 1'b1, 8'hFF);
    acc(2'd0, 3'd5, 1'b1, 8'hC1);
    chk_cfg;
    // Encoding per function number and unit
    meas(8'h11, 2'd0, 18'sd0, 16'sd0, 16'h0000, 1'b0, 1'b0, 16'hFFFF);
    meas(8'h11, 2'd0, 18'sd100000, 16'sd0, 16'h7FFF, 1'b1, 1'b0, 16'hFFFF);
    meas(8'h11, 2'd0, -18'sd100000, 16'sd0, 16'h8000, 1'b0, 1'b1, 16'hFFFF);
    meas(8'h21, 2'd0, 18'sd80000, 16'sd0, 16'h4000, 1'b0, 1'b0, 16'hFFFF);
    meas(8'hB1, 2'd0, 18'sd0, 16'sd13720, 16'd13720, 1'b0, 1'b0, 16'hFFFF);
    meas(8'hC1, 2'd0, 18'sd0, 16'sd16221, 16'h0000, 1'b1, 1'b0, 16'h0000);
    meas(8'hB0, 2'd0, 18'sd0, -16'sd2100, 16'hF7CC, 1'b0, 1'b0, 16'hFFFF);
    meas(8'hC0, 2'd0, 18'sd0, 16'sd14501, 16'h0000, 1'b1, 1'b0, 16'h0000);
    meas(8'hC1, 2'd1, 18'sd0, 16'sd13720, 16'd25016, 1'b0, 1'b0, 16'hFFFF);
    meas(8'hC1, 2'd2, 18'sd0, 16'sd16220, 16'd18952, 1'b0, 1'b0, 16'hFFFF);
    meas(8'hC1, 2'd2, 18'sd0, 16'sd0, 16'd2732, 1'b0, 1'b0, 16'hFFFF);
    meas(8'hFF, 2'd0, 18'sd0, 16'sd500, 16'h0000, 1'b0, 1'b0, 16'hFFFF);
    repeat (3) @(negedge core_clk_i);
    check(50'(aq.size() + mq.size()), 50'h0);
    print_verdict;
  end
endmodule : thermocouple_input_param_block_bench
`default_nettype wire
